// [common/gbs_pkg.sv]
// Package for the servo gain bank switcher: modes, field widths, timing.
// Assumes a 100 MHz system clock; the 100 us control tick is counted from it.
package gbs_pkg;

  localparam int CLK_MHZ         = 100;
  localparam int TICK_TIME_US    = 100;
  localparam int TICK_CYCLES     = (TICK_TIME_US * CLK_MHZ);
  localparam int PARAM_W         = 16;
  localparam int MODE_W          = 4;
  localparam int GAIN_W          = 16;
  localparam logic [15:0] TIME_MAX  = 16'h2710;
  localparam logic [15:0] LEVEL_MAX = 16'h4E20;
  localparam logic [15:0] LEVEL_RST = 16'h0000;
  localparam logic [15:0] DELAY_RST = 16'h0000;

  typedef enum logic [1:0]
  {
    CTRL_POS = 2'b00,
    CTRL_VEL = 2'b01,
    CTRL_TRQ = 2'b10
  } gbs_ctrl_type;

  localparam logic [3:0] M_FIRST    = 4'h0;
  localparam logic [3:0] M_SECOND   = 4'h1;
  localparam logic [3:0] M_RSVD     = 4'h2;
  localparam logic [3:0] M_TORQUE   = 4'h3;
  localparam logic [3:0] M_FIRST4   = 4'h4;
  localparam logic [3:0] M_VELVAR   = 4'h4;
  localparam logic [3:0] M_VELCMD   = 4'h5;
  localparam logic [3:0] M_DEVIAT   = 4'h6;
  localparam logic [3:0] M_CMDPRES  = 4'h7;
  localparam logic [3:0] M_NOTDONE  = 4'h8;
  localparam logic [3:0] M_SPEED    = 4'h9;
  localparam logic [3:0] M_CMDSPEED = 4'hA;

endpackage

// [verilog/gbs_ramp.sv]
`timescale 1ns/1ns
// Position loop gain ramp: limits the rise toward a new target gain.
// Steps once per control tick; falls are applied at once.
module gbs_ramp #(
  parameter int GAIN_W = 16
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Control
  input  wire logic              tick,
  input  wire logic [GAIN_W-1:0] target,
  input  wire logic [GAIN_W-1:0] step,
  input  wire logic              bypass,
  // Output
  output logic      [GAIN_W-1:0] gain
);
  logic [GAIN_W-1:0] gain_reg;
  logic [GAIN_W-1:0] gain_next;
  logic [GAIN_W:0]   sum;

  always_comb
  begin
    sum       = {1'b0, gain_reg} + {1'b0, step};
    gain_next = gain_reg;
    if (bypass || target <= gain_reg)
      gain_next = target;
    else if (tick)
    begin
      if (sum[GAIN_W] || sum[GAIN_W-1:0] >= target)
        gain_next = target;
      else
        gain_next = sum[GAIN_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      gain_reg <= '0;
    else
      gain_reg <= gain_next;
  end

  assign gain = gain_reg;
endmodule

// [verilog/gbs_switcher.sv]
`timescale 1ns/1ns
// Servo gain bank switcher: picks first or second gain set per control mode.
// Assumes trigger quantities are magnitudes on the system clock and that
// configuration is static while in use.
// Summary of operation
// R1 - Enable 0 keeps first gain; enable 1 allows first/second switching.
// R2 - Position modes 0..10; 0 and 4 first, 1 second, 3 torque.
// R3 - Position modes 5 vel, 6 dev, 7 cmd, 8 not done, 9 speed, 10 both.
// R4 - Position triggered modes hold second gain for delay before return.
// R5 - Position modes 3,5,6,9,10 compare trigger quantity against level.
// R6 - Those position modes apply programmable hysteresis to the comparison.
// R7 - Effective hysteresis is clamped to level when level is smaller.
// R8 - Software should program level not below hysteresis.
// R9 - Position loop gain rise is ramped over programmed time.
// R10 - Velocity modes 0..5: first, second, reserved, torque, variation, vel.
// R11 - Velocity triggered modes delay return to first gain.
// R12 - Velocity triggered modes use velocity level and hysteresis.
// R13 - Torque modes 0..3: first, second, reserved, torque command.
// R14 - Torque mode 3 delays return to first gain.
// R15 - Torque mode 3 uses torque level and hysteresis.
// R16 - Request sets above level plus hyst, clears below level minus hyst.
// R17 - Switch to second gain on the clock edge after the trigger appears.
module gbs_switcher #(
  parameter int PARAM_W = gbs_pkg::PARAM_W,
  parameter int GAIN_W  = gbs_pkg::GAIN_W,
  parameter int TICK_CYCLES = gbs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Configuration
  input  wire logic               gain_switch_enable,
  input  wire logic [1:0]         ctrl_mode,
  input  wire logic [3:0]         pos_switch_mode_sel,
  input  wire logic [PARAM_W-1:0] pos_switch_delay,
  input  wire logic [PARAM_W-1:0] pos_switch_level,
  input  wire logic [PARAM_W-1:0] pos_switch_hyst,
  input  wire logic [PARAM_W-1:0] pos_gain_ramp_time,
  input  wire logic [3:0]         vel_switch_mode_sel,
  input  wire logic [PARAM_W-1:0] vel_switch_delay,
  input  wire logic [PARAM_W-1:0] vel_switch_level,
  input  wire logic [PARAM_W-1:0] vel_switch_hyst,
  input  wire logic [3:0]         trq_switch_mode_sel,
  input  wire logic [PARAM_W-1:0] trq_switch_delay,
  input  wire logic [PARAM_W-1:0] trq_switch_level,
  input  wire logic [PARAM_W-1:0] trq_switch_hyst,
  input  wire logic [GAIN_W-1:0]  first_pos_loop_gain,
  input  wire logic [GAIN_W-1:0]  second_pos_loop_gain,
  // Trigger quantities from the control loops
  input  wire logic [PARAM_W-1:0] torque_cmd_mag,
  input  wire logic [PARAM_W-1:0] vel_cmd_mag,
  input  wire logic [PARAM_W-1:0] vel_cmd_var_mag,
  input  wire logic [PARAM_W-1:0] pos_dev_mag,
  input  wire logic [PARAM_W-1:0] actual_speed_mag,
  input  wire logic               pos_cmd_present,
  input  wire logic               positioning_done,
  // Status and outputs
  output logic                    second_gain_sel,
  output logic                    trigger_active,
  output logic                    mode_reserved,
  output logic [GAIN_W-1:0]       pos_loop_gain
);

  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_reg;
  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_next;
  logic                           tick;
  logic [PARAM_W-1:0]             delay_cnt_reg;
  logic [PARAM_W-1:0]             delay_cnt_next;
  logic                           sel_reg;
  logic                           sel_next;
  logic                           req_reg;
  logic                           req_next;
  logic [3:0]                     mode;
  logic [PARAM_W-1:0]             level;
  logic [PARAM_W-1:0]             hyst;
  logic [PARAM_W-1:0]             hyst_eff;
  logic [PARAM_W-1:0]             delay;
  logic [PARAM_W-1:0]             qty;
  logic                           use_level;
  logic                           force_first;
  logic                           force_second;
  logic                           flag_trig;
  logic                           flag_val;
  logic                           trig;
  logic [PARAM_W:0]               upper;
  logic [PARAM_W:0]               lower;
  logic [GAIN_W-1:0]              ramp_step;
  logic [GAIN_W-1:0]              gain_diff;

  // Control tick of 0.1 ms for delay and ramp timing
  always_comb
  begin
    tick          = (tick_cnt_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
    tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
  end

  // Per control mode selection of mode, thresholds and delay
  always_comb
  begin
    mode         = pos_switch_mode_sel;
    level        = pos_switch_level;
    hyst         = pos_switch_hyst;
    delay        = pos_switch_delay;
    use_level    = 1'b0;
    force_first  = 1'b0;
    force_second = 1'b0;
    flag_trig    = 1'b0;
    flag_val     = 1'b0;
    qty          = '0;
    unique case (ctrl_mode)
      gbs_pkg::CTRL_VEL:
      begin
        mode  = vel_switch_mode_sel;
        level = vel_switch_level;
        hyst  = vel_switch_hyst;
        delay = vel_switch_delay;
        use_level = 1'b1; // R12
        unique case (mode) // R10
          gbs_pkg::M_FIRST:  force_first = 1'b1;
          gbs_pkg::M_SECOND: force_second = 1'b1;
          gbs_pkg::M_TORQUE: qty = torque_cmd_mag;
          gbs_pkg::M_VELVAR: qty = vel_cmd_var_mag;
          gbs_pkg::M_VELCMD: qty = vel_cmd_mag;
          default:           force_first = 1'b1;
        endcase
      end
      gbs_pkg::CTRL_TRQ:
      begin
        mode  = trq_switch_mode_sel;
        level = trq_switch_level;
        hyst  = trq_switch_hyst;
        delay = trq_switch_delay; // R14
        use_level = 1'b1; // R15
        unique case (mode) // R13
          gbs_pkg::M_SECOND: force_second = 1'b1;
          gbs_pkg::M_TORQUE: qty = torque_cmd_mag;
          default:           force_first = 1'b1;
        endcase
      end
      default:
      begin
        unique case (mode) // R2 R3
          gbs_pkg::M_SECOND: force_second = 1'b1;
          gbs_pkg::M_TORQUE:
          begin
            qty = torque_cmd_mag;
            use_level = 1'b1; // R5
          end
          gbs_pkg::M_VELCMD:
          begin
            qty = vel_cmd_mag;
            use_level = 1'b1;
          end
          gbs_pkg::M_DEVIAT:
          begin
            qty = pos_dev_mag;
            use_level = 1'b1;
          end
          gbs_pkg::M_CMDPRES:
          begin
            flag_trig = 1'b1;
            flag_val  = pos_cmd_present;
          end
          gbs_pkg::M_NOTDONE:
          begin
            flag_trig = 1'b1;
            flag_val  = !positioning_done;
          end
          gbs_pkg::M_SPEED:
          begin
            qty = actual_speed_mag;
            use_level = 1'b1;
          end
          gbs_pkg::M_CMDSPEED:
          begin
            qty = actual_speed_mag;
            use_level = 1'b1;
            flag_trig = 1'b1;
            flag_val  = pos_cmd_present;
          end
          default: force_first = 1'b1;
        endcase
      end
    endcase
  end

  // Hysteresis clamp guards against a negative lower threshold
  always_comb
  begin
    hyst_eff = (level < hyst) ? level : hyst; // R7
    upper    = {1'b0, level} + {1'b0, hyst_eff}; // R6
    lower    = {1'b0, level} - {1'b0, hyst_eff};
    if (!req_reg) // R16
      req_next = ({1'b0, qty} > upper);
    else
      req_next = !({1'b0, qty} < lower);
    if (!use_level)
      req_next = 1'b0;
    trig = (use_level && req_next) || (flag_trig && flag_val);
  end

  // Gain selection with immediate rise and delayed return
  always_comb
  begin
    sel_next       = sel_reg;
    delay_cnt_next = delay_cnt_reg;
    if (!gain_switch_enable || force_first) // R1
    begin
      sel_next       = 1'b0;
      delay_cnt_next = '0;
    end
    else if (force_second)
    begin
      sel_next       = 1'b1;
      delay_cnt_next = '0;
    end
    else if (trig)
    begin
      sel_next       = 1'b1; // R17
      delay_cnt_next = '0;
    end
    else if (sel_reg)
    begin
      // R4 R11 R14
      if (delay_cnt_reg >= delay)
        sel_next = 1'b0;
      else if (tick)
        delay_cnt_next = delay_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_reg  <= '0;
      delay_cnt_reg <= '0;
      sel_reg       <= 1'b0;
      req_reg       <= 1'b0;
    end
    else
    begin
      tick_cnt_reg  <= tick_cnt_next;
      delay_cnt_reg <= delay_cnt_next;
      sel_reg       <= sel_next;
      req_reg       <= req_next;
    end
  end

  // Ramp step per tick; integer divide trades exact time for small area
  always_comb
  begin
    gain_diff = (second_pos_loop_gain > first_pos_loop_gain)
              ? second_pos_loop_gain - first_pos_loop_gain
              : first_pos_loop_gain - second_pos_loop_gain;
    ramp_step = (pos_gain_ramp_time == '0) ? gain_diff
              : GAIN_W'(gain_diff / pos_gain_ramp_time);
    if (ramp_step == '0)
      ramp_step = GAIN_W'(1);
  end

  gbs_ramp #(
    .GAIN_W (GAIN_W)
  ) u_ramp (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (tick),
    .target  (sel_reg ? second_pos_loop_gain : first_pos_loop_gain),
    .step    (ramp_step),
    .bypass  (ctrl_mode != gbs_pkg::CTRL_POS), // R9
    .gain    (pos_loop_gain)
  );

  assign second_gain_sel = sel_reg;
  assign trigger_active  = trig;
  assign mode_reserved   = (mode == gbs_pkg::M_RSVD);

  AST_DISABLED_FIRST: assert property ( // R1
    @(posedge clk_sys) disable iff (rst)
    !gain_switch_enable |=> !second_gain_sel)
    else $error("second gain while switching disabled");
  AST_FORCE_FIRST: assert property ( // R2
    @(posedge clk_sys) disable iff (rst)
    (gain_switch_enable && ctrl_mode == gbs_pkg::CTRL_POS &&
     pos_switch_mode_sel == gbs_pkg::M_FIRST4) |=> !second_gain_sel)
    else $error("mode four did not force first gain");
  AST_FAST_RISE: assert property ( // R17
    @(posedge clk_sys) disable iff (rst)
    (gain_switch_enable && trig && !force_first) |=> second_gain_sel)
    else $error("second gain not taken on trigger");
  AST_HOLD_DELAY: assert property ( // R4
    @(posedge clk_sys) disable iff (rst)
    (second_gain_sel && gain_switch_enable && !force_first &&
     delay_cnt_reg < delay && $stable(ctrl_mode)) |=> second_gain_sel)
    else $error("first gain returned before delay");
  // A clamp that failed would wrap the lower threshold past zero
  AST_CLAMP: assert property ( // R7
    @(posedge clk_sys) disable iff (rst)
    !lower[PARAM_W])
    else $error("lower threshold wrapped below zero");
  AST_SET_ABOVE: assert property ( // R16
    @(posedge clk_sys) disable iff (rst)
    (use_level && {1'b0, qty} > upper) |=> req_reg)
    else $error("request not set above upper threshold");
  AST_CLR_BELOW: assert property ( // R16
    @(posedge clk_sys) disable iff (rst)
    (use_level && {1'b0, qty} < lower) |=> !req_reg)
    else $error("request not cleared below lower threshold");
  AST_RAMP_NO_JUMP: assert property ( // R9
    @(posedge clk_sys) disable iff (rst)
    (ctrl_mode == gbs_pkg::CTRL_POS && !tick &&
     $stable(ctrl_mode) && pos_loop_gain < (sel_reg ?
     second_pos_loop_gain : first_pos_loop_gain))
    |=> !($past(pos_loop_gain) < pos_loop_gain))
    else $error("position gain rose without tick");
  AST_TRQ_FIRST: assert property ( // R13
    @(posedge clk_sys) disable iff (rst)
    (ctrl_mode == gbs_pkg::CTRL_TRQ &&
     trq_switch_mode_sel == gbs_pkg::M_FIRST) |=> !second_gain_sel)
    else $error("torque mode zero not first gain");

  COV_RISE: cover property (@(posedge clk_sys) disable iff (rst)
    !second_gain_sel ##1 second_gain_sel);
  COV_RETURN: cover property (@(posedge clk_sys) disable iff (rst)
    second_gain_sel ##1 !second_gain_sel);
  COV_VEL_TRIG: cover property (@(posedge clk_sys) disable iff (rst)
    ctrl_mode == gbs_pkg::CTRL_VEL && trig);
  COV_CLAMP: cover property (@(posedge clk_sys) disable iff (rst)
    use_level && level < hyst);
endmodule

// [tb/gbs_loop_model.sv]
// Model of the servo loops that consume the selected gain set.
// Assumes second_gain_sel is registered on clk_sys.
`timescale 1ns/1ns
module gbs_loop_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // From the switcher
  input  wire logic second_gain_sel,
  // Status
  output int        switch_count
);
  logic sel_prev_reg;

  // Counts entries into the second set, the moments the loops retune
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sel_prev_reg <= 1'b0;
      switch_count <= 0;
    end
    else
    begin
      sel_prev_reg <= second_gain_sel;
      if (second_gain_sel && !sel_prev_reg)
        switch_count <= switch_count + 1;
    end
  end
endmodule

// [tb/tb_gbs_switcher.sv]
// Self-checking bench for the gain bank switcher.
// Assumes a short control tick (10 clocks) to keep runs short.
`timescale 1ns/1ns
module tb_gbs_switcher;
  localparam int TK = 10;
  logic        clk_sys, rst, ena, pcmd, pdone, sel, trig, rsvd, armed;
  logic [1:0]  ctrl;
  logic [3:0]  pmode, vmode, tmode;
  logic [15:0] pdly, plvl, phys, ramp, vdly, vlvl, vhys;
  logic [15:0] tdly, tlvl, thys, g1, g2, gain;
  logic [15:0] qty [5];
  logic        q [$];
  int          err_total, check_count, sw_exp, sw_seen;
  int          lc [9] = '{0, 0, 0, 0, 0, 1, 1, 1, 2};
  int          lm [9] = '{3, 5, 6, 9, 10, 3, 4, 5, 3};
  int          ls [9] = '{0, 1, 3, 4, 4, 0, 2, 1, 0};

  gbs_switcher #(.TICK_CYCLES(TK)) dut (
    .clk_sys(clk_sys), .rst(rst), .gain_switch_enable(ena),
    .ctrl_mode(ctrl), .pos_switch_mode_sel(pmode),
    .pos_switch_delay(pdly), .pos_switch_level(plvl),
    .pos_switch_hyst(phys), .pos_gain_ramp_time(ramp),
    .vel_switch_mode_sel(vmode), .vel_switch_delay(vdly),
    .vel_switch_level(vlvl), .vel_switch_hyst(vhys),
    .trq_switch_mode_sel(tmode), .trq_switch_delay(tdly),
    .trq_switch_level(tlvl), .trq_switch_hyst(thys),
    .first_pos_loop_gain(g1), .second_pos_loop_gain(g2),
    .torque_cmd_mag(qty[0]), .vel_cmd_mag(qty[1]),
    .vel_cmd_var_mag(qty[2]), .pos_dev_mag(qty[3]),
    .actual_speed_mag(qty[4]), .pos_cmd_present(pcmd),
    .positioning_done(pdone), .second_gain_sel(sel),
    .trigger_active(trig), .mode_reserved(rsvd), .pos_loop_gain(gain));

  gbs_loop_model partner (
    .clk_sys(clk_sys), .rst(rst), .second_gain_sel(sel),
    .switch_count(sw_seen));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h",
               $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Notes the expected level for the watcher below; checks and ends the run itself if sel misses it within n cycles
  task automatic expect_sel(input logic v, input int n);
    q.push_back(v);
    if (v)
      sw_exp++;
    for (int i = 0; i < n && sel !== v; i++)
      cyc(1);
    if (sel !== v)
    begin
      check(16'(sel), 16'(v));
      close_out();
    end
  endtask

  // Any change while holding finds an empty queue and is flagged
  task automatic hold(input logic v, input int n);
    cyc(n);
    check(16'(sel), 16'(v));
  endtask

  task automatic wait_gain(input logic [15:0] v, input int n);
    for (int i = 0; i < n && gain !== v; i++)
      cyc(1);
    check(gain, v);
    if (gain !== v)
      close_out();
  endtask

  task automatic set_mode(input int c, input int m);
    ctrl  = 2'(c);
    pmode = (c == 0) ? 4'(m) : 4'h0;
    vmode = (c == 1) ? 4'(m) : 4'h0;
    tmode = (c == 2) ? 4'(m) : 4'h0;
  endtask

  // Unselected domains get zero thresholds so a wrong pick shows up
  task automatic set_cfg(input int c, input logic [15:0] l, h, d);
    {plvl, phys, pdly} = (c == 0) ? {l, h, d} : 48'h0;
    {vlvl, vhys, vdly} = (c == 1) ? {l, h, d} : 48'h0;
    {tlvl, thys, tdly} = (c == 2) ? {l, h, d} : 48'h0;
  endtask

  task automatic set_qty(input int s, input logic [15:0] v);
    foreach (qty[k])
      qty[k] = (k == s) ? v : 16'h0000;
  endtask

  always @(sel)
    if (armed)
    begin
      if (q.size() == 0)
        check(16'(sel), 16'(~sel));
      else
        check(16'(sel), 16'(q.pop_front()));
    end

  initial
  begin
    logic [15:0] lvl, hys;
    rst = 1'b1;
    armed = 1'b0;
    {ena, pcmd, pdone} = 3'b101;
    {g1, g2, ramp} = {16'h0064, 16'h01F4, 16'h0004};
    {err_total, check_count, sw_exp} = '0;
    set_mode(0, 0);
    set_cfg(0, 16'h0000, 16'h0000, 16'h0000);
    set_qty(0, 16'h0000);
    void'($urandom(12));
    cyc(8);
    rst = 1'b0;
    armed = 1'b1;
    ena = 1'b0;
    set_mode(0, 1);
    hold(0, 20);
    ena = 1'b1;
    expect_sel(1, 2);
    set_mode(0, 0);
    expect_sel(0, 2);
    $display("test done: enable");
    for (int c = 0; c < 3; c++)
      for (int m = 0; m < 3; m++)
      begin
        set_mode(c, m);
        #1 check(16'(rsvd), 16'(m == 2));
        if (m == 1)
        begin
          expect_sel(1, 2);
          set_mode(c, 0);
          expect_sel(0, 2);
        end
        else
          hold(0, 3);
      end
    // Mode 4 in position control ignores a huge torque
    set_mode(0, 4);
    set_qty(0, 16'hFFFF);
    hold(0, 5);
    $display("test done: fixed modes");
    for (int i = 0; i < 9; i++)
    begin
      lvl = 16'(100 + $urandom % 1000);
      hys = 16'($urandom % 50);
      set_cfg(lc[i], lvl, hys, 16'h0000);
      set_mode(lc[i], lm[i]);
      set_qty(ls[i], lvl + hys);
      #1 check(16'(trig), 16'h0000);
      hold(0, 3);
      set_qty(ls[i], lvl + hys + 16'h0001);
      #1 check(16'(trig), 16'h0001);
      expect_sel(1, 1);
      set_qty(ls[i], lvl - hys);
      hold(1, 3);
      set_qty(ls[i], lvl - hys - 16'h0001);
      expect_sel(0, 2);
    end
    $display("test done: level and hysteresis");
    set_cfg(0, 16'h0014, 16'h0032, 16'h0000);
    set_mode(0, 9);
    set_qty(4, 16'h0028);
    hold(0, 3);
    set_qty(4, 16'h0029);
    expect_sel(1, 1);
    set_qty(4, 16'h0000);
    hold(1, 5);
    set_mode(0, 0);
    expect_sel(0, 2);
    $display("test done: hysteresis clamp");
    set_mode(0, 7);
    pcmd = 1'b1;
    expect_sel(1, 1);
    pcmd = 1'b0;
    expect_sel(0, 2);
    set_mode(0, 8);
    pdone = 1'b0;
    expect_sel(1, 1);
    pdone = 1'b1;
    expect_sel(0, 2);
    set_mode(0, 10);
    pcmd = 1'b1;
    expect_sel(1, 1);
    pcmd = 1'b0;
    expect_sel(0, 2);
    $display("test done: flag triggers");
    for (int c = 0; c < 3; c++)
    begin
      set_cfg(c, 16'h0064, 16'h0000, 16'h0003);
      set_mode(c, 3);
      set_qty(0, 16'h00C8);
      expect_sel(1, 1);
      set_qty(0, 16'h0000);
      hold(1, 2 * TK - 1);
      expect_sel(0, 2 * TK + 5);
    end
    $display("test done: return delay");
    set_mode(0, 0);
    wait_gain(g1, 20 * TK);
    set_mode(0, 1);
    expect_sel(1, 2);
    cyc(2 * TK + 5);
    check(16'(gain < g2), 16'h0001);
    wait_gain(g2, 6 * TK);
    set_mode(0, 0);
    expect_sel(0, 2);
    cyc(1);
    check(gain, g1);
    $display("test done: gain ramp");
    check(16'(sw_seen), 16'(sw_exp));
    close_out();
  end
endmodule
